// ==== core/fbr_regs.svh ====
// Special-register numbers, field positions, reset values and masks
// Operation
// RQ1: Overflow set by instructions also sets summary overflow.
// RQ2: Summary overflow cleared only by move or copy.
// RQ3: Move with summary zero, overflow one keeps that.
// RQ4: Add-type overflow is carry-in xor carry-out of msb.
// RQ5: Multiply/divide overflow when result exceeds width.
// RQ6: Compares and non-overflowing ops keep both overflow flags.
// RQ7: Carrying and extended adds set carry from msb.
// RQ8: Arithmetic right shift carry: negative, ones shifted out.
// RQ9: Carry kept by compares and carry-free operations.
// RQ10: String byte count comes from bits 25-31.
// RQ11: Flags come from the complete multi-operand result.
// RQ12: Link keeps all bits; target ignores low two.
// RQ13: Link update writes the following instruction address.
// RQ14: Link register is special number 8, branch target.
// RQ15: Decrementing zero count wraps to all ones.
// RQ16: Count register is special number 9, branch target.
// RQ17: Options 0000/0001 decrement, branch on false condition.
// RQ18: Options 0100/0101 decrement, branch on true condition.
// RQ19: Options 001/011 test condition, count untouched.
// RQ20: Leading options bit set ignores the condition.
// RQ21: Hint bit predicts only, never changes the outcome.
// RQ22: Ignored options bits should be zero; disregarded.
// RQ23: Decremented count written back always, branch uses it.
`ifndef FBR_REGS_SVH
`define FBR_REGS_SVH

// Special-register numbers on the move port
`define FBR_SPR_FLAGS 10'h001
`define FBR_SPR_LINK 10'h008
`define FBR_SPR_COUNT 10'h009

// Flag positions, bit 0 of the printed layout is our bit 31
`define FBR_SO_BIT 31
`define FBR_OVF_BIT 30
`define FBR_CRY_BIT 29
`define FBR_BCNT_HI 6
`define FBR_BCNT_LO 0
`define FBR_FLAGS_WMASK 32'he000_007f

// Reset values
`define FBR_FLAGS_RST 32'h0000_0000
`define FBR_LINK_RST 32'h0000_0000
`define FBR_COUNT_RST 32'h0000_0000

// Count wrap value and branch address alignment
`define FBR_COUNT_WRAP 32'hffff_ffff
`define FBR_ADDR_MASK 32'hffff_fffc

// Branch-options field bit positions
`define FBR_BR_IGN_COND 4
`define FBR_BR_COND_VAL 3
`define FBR_BR_NO_DEC 2
`define FBR_BR_ON_ZERO 1
`define FBR_BR_HINT 0

`endif

// ==== core/fbr_pkg.sv ====
// Types shared by the flags, link and count block
package fbr_pkg;

    typedef enum logic [2:0] {
        FBR_OP_ADD = 3'h0,
        FBR_OP_MULW = 3'h1,
        FBR_OP_DIVW = 3'h2,
        FBR_OP_DIVWU = 3'h3,
        FBR_OP_SRAW = 3'h4,
        FBR_OP_CMP = 3'h5,
        FBR_OP_OTHER = 3'h6
    } fbr_op_type;

    typedef enum logic [1:0] {
        FBR_CIN_ZERO = 2'h0,
        FBR_CIN_ONE = 2'h1,
        FBR_CIN_CARRY = 2'h2
    } fbr_cin_type;

    typedef enum logic [1:0] {
        FBR_TGT_DIRECT = 2'h0,
        FBR_TGT_LINK = 2'h1,
        FBR_TGT_COUNT = 2'h2
    } fbr_tgt_type;

    // One fixed-point operation as issued by the execution unit
    typedef struct packed {
        fbr_op_type op;
        logic ovf_en;
        logic carry_en;
        logic invert_a;
        fbr_cin_type cin;
        logic [31:0] opnd_a;
        logic [31:0] opnd_b;
    } fbr_alu_req_type;

    // One conditional branch as issued by the decoder
    typedef struct packed {
        logic [4:0] options;
        logic cond_bit;
        logic link_en;
        fbr_tgt_type tgt;
        logic [31:0] next_addr;
        logic [31:0] direct_addr;
    } fbr_br_req_type;

    // Branch outcome
    typedef struct packed {
        logic taken;
        logic hint;
        logic [31:0] target;
    } fbr_br_res_type;

endpackage

// ==== core/fbr_branch_eval.sv ====
// Branch-options decode: count decrement and taken decision
`timescale 1ns/100ps
`include "fbr_regs.svh"
module fbr_branch_eval
    import fbr_pkg::*;
(
    input wire logic [4:0] options_i,
    input wire logic cond_bit_i,
    input wire logic [31:0] count_i,
    output logic dec_en_o,
    output logic [31:0] count_next_o,
    output logic taken_o,
    output logic hint_o
);

    logic cnt_ok;
    logic cond_ok;

    // Decrement unless the no-decrement bit is set; zero wraps
    always_comb
    begin
        dec_en_o = ~options_i[`FBR_BR_NO_DEC]; // see RQ17 see RQ18 see RQ20
        if (count_i == 32'h0000_0000)
        begin
            count_next_o = `FBR_COUNT_WRAP; // see RQ15
        end
        else
        begin
            count_next_o = count_i - 32'h0000_0001;
        end
    end

    // Test the new count, never the old one
    assign cnt_ok = options_i[`FBR_BR_NO_DEC] |
        ((count_next_o != 32'h0000_0000) ^ options_i[`FBR_BR_ON_ZERO]); // see RQ23
    // Condition test, skipped when the leading bit is set
    assign cond_ok = options_i[`FBR_BR_IGN_COND] |
        (cond_bit_i == options_i[`FBR_BR_COND_VAL]); // see RQ19 see RQ20
    // Ignored z bits fall out of both terms, so their value is irrelevant
    assign taken_o = cnt_ok & cond_ok; // see RQ22
    // Hint only echoed for the fetch predictor, not in taken_o
    assign hint_o = options_i[`FBR_BR_HINT]; // see RQ21

endmodule // fbr_branch_eval

// ==== core/fbr_core.sv ====
// Fixed-point flags, link and count registers with branch resolution
`timescale 1ns/100ps
`include "fbr_regs.svh"
module fbr_core
    import fbr_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic CLK_EN_I,
    input wire logic SPR_WR_I,
    input wire logic SPR_RD_I,
    input wire logic [9:0] SPR_NUM_I,
    input wire logic [31:0] SPR_WDATA_I,
    output logic [31:0] SPR_RDATA_O,
    output logic SPR_RVALID_O,
    output logic SPR_BAD_O,
    input wire logic COPY_FLAGS_I,
    output logic [3:0] CR_FIELD_O,
    output logic CR_FIELD_VALID_O,
    input wire logic ALU_VALID_I,
    input wire fbr_alu_req_type ALU_REQ_I,
    output logic ALU_DONE_O,
    output logic SUMMARY_OVF_O,
    output logic OVERFLOW_O,
    output logic CARRY_O,
    output logic [6:0] STRING_BYTES_O,
    input wire logic BR_VALID_I,
    input wire fbr_br_req_type BR_REQ_I,
    output logic BR_DONE_O,
    output fbr_br_res_type BR_RES_O,
    output logic [31:0] LINK_O,
    output logic [31:0] COUNT_O
);

    logic [31:0] flags_reg;
    logic [31:0] flags_next;
    logic [31:0] link_reg;
    logic [31:0] link_next;
    logic [31:0] count_reg;
    logic [31:0] count_next;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    logic bad_reg;
    logic [3:0] cr_field_reg;
    logic cr_valid_reg;
    logic alu_done_reg;
    logic br_done_reg;
    fbr_br_res_type br_res_reg;

    logic hit_flags;
    logic hit_link;
    logic hit_count;
    logic hit_any;

    logic [31:0] add_x;
    logic cin_bit;
    logic [32:0] sum33;
    logic carry_into_msb;
    logic add_ovf;
    logic [63:0] product;
    logic mul_ovf;
    logic divw_ovf;
    logic divwu_ovf;
    logic [31:0] shift_mask;
    logic shift_lost;
    logic sra_cry;
    logic ovf_upd;
    logic ovf_val;
    logic cry_upd;
    logic cry_val;

    logic br_dec_en;
    logic [31:0] br_count_dec;
    logic br_taken;
    logic br_hint;
    logic [31:0] br_target;

    // Special-register number decode
    assign hit_flags = (SPR_NUM_I == `FBR_SPR_FLAGS);
    assign hit_link = (SPR_NUM_I == `FBR_SPR_LINK); // see RQ14
    assign hit_count = (SPR_NUM_I == `FBR_SPR_COUNT); // see RQ16
    assign hit_any = hit_flags | hit_link | hit_count;

    // Add-type datapath: all three operands summed as one, no partial sum
    always_comb
    begin
        add_x = ALU_REQ_I.invert_a ? ~ALU_REQ_I.opnd_a : ALU_REQ_I.opnd_a;
        unique case (ALU_REQ_I.cin)
            FBR_CIN_ZERO: cin_bit = 1'b0;
            FBR_CIN_ONE: cin_bit = 1'b1;
            FBR_CIN_CARRY: cin_bit = flags_reg[`FBR_CRY_BIT];
            default: cin_bit = 1'b0;
        endcase
    end

    assign sum33 = {1'b0, add_x} + {1'b0, ALU_REQ_I.opnd_b} + {32'h0000_0000, cin_bit}; // see RQ11
    // Carry into the msb is recovered from the msb sum bit
    assign carry_into_msb = add_x[31] ^ ALU_REQ_I.opnd_b[31] ^ sum33[31];
    assign add_ovf = sum33[32] ^ carry_into_msb; // see RQ4

    // Word multiply overflows when the high half is not a sign extension
    assign product = $signed(ALU_REQ_I.opnd_a) * $signed(ALU_REQ_I.opnd_b);
    assign mul_ovf = ~((&product[63:31]) | ~(|product[63:31])); // see RQ5

    // Divide cases whose quotient has no 32-bit form
    assign divw_ovf = (ALU_REQ_I.opnd_b == 32'h0000_0000) |
        ((ALU_REQ_I.opnd_a == 32'h8000_0000) & (ALU_REQ_I.opnd_b == 32'hffff_ffff)); // see RQ5
    assign divwu_ovf = (ALU_REQ_I.opnd_b == 32'h0000_0000); // see RQ5

    // Arithmetic right shift: six-bit amount, 32 or more shifts out all bits
    assign shift_mask = ~(32'hffff_ffff << ALU_REQ_I.opnd_b[4:0]);
    assign shift_lost = ALU_REQ_I.opnd_b[5] ? (ALU_REQ_I.opnd_a != 32'h0000_0000) :
        ((ALU_REQ_I.opnd_a & shift_mask) != 32'h0000_0000);
    assign sra_cry = ALU_REQ_I.opnd_a[31] & shift_lost; // see RQ8

    // Which flags an operation touches, and with what
    always_comb
    begin
        ovf_upd = 1'b0;
        ovf_val = 1'b0;
        cry_upd = 1'b0;
        cry_val = 1'b0;
        unique case (ALU_REQ_I.op)
            FBR_OP_ADD:
            begin
                ovf_upd = ALU_REQ_I.ovf_en; // see RQ4
                ovf_val = add_ovf;
                cry_upd = ALU_REQ_I.carry_en; // see RQ7
                cry_val = sum33[32];
            end
            FBR_OP_MULW:
            begin
                ovf_upd = ALU_REQ_I.ovf_en;
                ovf_val = mul_ovf;
            end
            FBR_OP_DIVW:
            begin
                ovf_upd = ALU_REQ_I.ovf_en;
                ovf_val = divw_ovf;
            end
            FBR_OP_DIVWU:
            begin
                ovf_upd = ALU_REQ_I.ovf_en;
                ovf_val = divwu_ovf;
            end
            FBR_OP_SRAW:
            begin
                cry_upd = 1'b1; // see RQ8
                cry_val = sra_cry;
            end
            // Compares and the rest leave every flag alone
            FBR_OP_CMP, FBR_OP_OTHER:
            begin
                ovf_upd = 1'b0; // see RQ6 see RQ9
                cry_upd = 1'b0;
            end
            default:
            begin
                ovf_upd = 1'b0;
                cry_upd = 1'b0;
            end
        endcase
    end

    // Flags next value: explicit clears first, hardware sets last so they win
    always_comb
    begin
        flags_next = flags_reg;
        if (SPR_WR_I && hit_flags)
        begin
            flags_next = SPR_WDATA_I & `FBR_FLAGS_WMASK; // see RQ2 see RQ3
        end
        if (COPY_FLAGS_I)
        begin
            flags_next[`FBR_SO_BIT] = 1'b0; // see RQ2
            flags_next[`FBR_OVF_BIT] = 1'b0;
            flags_next[`FBR_CRY_BIT] = 1'b0;
        end
        if (ALU_VALID_I)
        begin
            if (ovf_upd)
            begin
                flags_next[`FBR_OVF_BIT] = ovf_val;
                if (ovf_val)
                begin
                    flags_next[`FBR_SO_BIT] = 1'b1; // see RQ1
                end
            end
            if (cry_upd)
            begin
                flags_next[`FBR_CRY_BIT] = cry_val; // see RQ7 see RQ8
            end
        end
    end

    // Flags register
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            flags_reg <= `FBR_FLAGS_RST;
        end
        else if (CLK_EN_I)
        begin
            flags_reg <= flags_next;
        end
    end

    // Branch-options decode against the current count
    fbr_branch_eval u_eval (
        .options_i(BR_REQ_I.options),
        .cond_bit_i(BR_REQ_I.cond_bit),
        .count_i(count_reg),
        .dec_en_o(br_dec_en),
        .count_next_o(br_count_dec),
        .taken_o(br_taken),
        .hint_o(br_hint)
    );

    // Target: register sources drop their low two bits, stored bits stay
    always_comb
    begin
        unique case (BR_REQ_I.tgt)
            FBR_TGT_LINK: br_target = link_reg & `FBR_ADDR_MASK; // see RQ12 see RQ14
            FBR_TGT_COUNT: br_target = count_reg & `FBR_ADDR_MASK; // see RQ16
            FBR_TGT_DIRECT: br_target = BR_REQ_I.direct_addr;
            default: br_target = BR_REQ_I.direct_addr;
        endcase
    end

    // Link next value; a branch in the same cycle is the later writer
    always_comb
    begin
        link_next = link_reg;
        if (SPR_WR_I && hit_link)
        begin
            link_next = SPR_WDATA_I; // see RQ12
        end
        if (BR_VALID_I && BR_REQ_I.link_en)
        begin
            link_next = BR_REQ_I.next_addr; // see RQ13
        end
    end

    // Count next value; decrement stored whether taken or not
    always_comb
    begin
        count_next = count_reg;
        if (SPR_WR_I && hit_count)
        begin
            count_next = SPR_WDATA_I;
        end
        if (BR_VALID_I && br_dec_en)
        begin
            count_next = br_count_dec; // see RQ23 see RQ15
        end
    end

    // Link and count registers
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            link_reg <= `FBR_LINK_RST;
            count_reg <= `FBR_COUNT_RST;
        end
        else if (CLK_EN_I)
        begin
            link_reg <= link_next;
            count_reg <= count_next;
        end
    end

    // Branch outcome, one cycle after the request
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            br_done_reg <= 1'b0;
            br_res_reg <= '0;
        end
        else if (CLK_EN_I)
        begin
            br_done_reg <= BR_VALID_I;
            if (BR_VALID_I)
            begin
                br_res_reg.taken <= br_taken; // see RQ17 see RQ18 see RQ19 see RQ20
                br_res_reg.hint <= br_hint; // see RQ21
                br_res_reg.target <= br_target;
            end
        end
    end

    // Move-from port: reads see values before this cycle's updates
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rdata_reg <= 32'h0000_0000;
            rvalid_reg <= 1'b0;
            bad_reg <= 1'b0;
        end
        else if (CLK_EN_I)
        begin
            rvalid_reg <= SPR_RD_I & hit_any;
            bad_reg <= (SPR_RD_I | SPR_WR_I) & ~hit_any;
            if (SPR_RD_I)
            begin
                if (hit_flags)
                begin
                    rdata_reg <= flags_reg;
                end
                else if (hit_link)
                begin
                    rdata_reg <= link_reg; // see RQ14
                end
                else if (hit_count)
                begin
                    rdata_reg <= count_reg; // see RQ16
                end
                else
                begin
                    rdata_reg <= 32'h0000_0000;
                end
            end
        end
    end

    // Copy of the three flags toward the condition field, old values
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            cr_field_reg <= 4'h0;
            cr_valid_reg <= 1'b0;
            alu_done_reg <= 1'b0;
        end
        else if (CLK_EN_I)
        begin
            cr_valid_reg <= COPY_FLAGS_I;
            alu_done_reg <= ALU_VALID_I;
            if (COPY_FLAGS_I)
            begin
                cr_field_reg <= {flags_reg[`FBR_SO_BIT], flags_reg[`FBR_OVF_BIT],
                    flags_reg[`FBR_CRY_BIT], 1'b0};
            end
        end
    end

    // Outputs, all taken straight from registers
    assign SPR_RDATA_O = rdata_reg;
    assign SPR_RVALID_O = rvalid_reg;
    assign SPR_BAD_O = bad_reg;
    assign CR_FIELD_O = cr_field_reg;
    assign CR_FIELD_VALID_O = cr_valid_reg;
    assign ALU_DONE_O = alu_done_reg;
    assign SUMMARY_OVF_O = flags_reg[`FBR_SO_BIT];
    assign OVERFLOW_O = flags_reg[`FBR_OVF_BIT];
    assign CARRY_O = flags_reg[`FBR_CRY_BIT];
    assign STRING_BYTES_O = flags_reg[`FBR_BCNT_HI:`FBR_BCNT_LO]; // see RQ10
    assign BR_DONE_O = br_done_reg;
    assign BR_RES_O = br_res_reg;
    assign LINK_O = link_reg;
    assign COUNT_O = count_reg;

endmodule // fbr_core

// ==== testbench/fbr_core_props.sv ====
// Concurrent checks on the flags, link and count block ports
`timescale 1ns/100ps
`include "fbr_regs.svh"
module fbr_core_props
    import fbr_pkg::*;
(
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic CLK_EN_I,
    input wire logic SPR_WR_I,
    input wire logic SPR_RD_I,
    input wire logic [9:0] SPR_NUM_I,
    input wire logic [31:0] SPR_RDATA_O,
    input wire logic SPR_RVALID_O,
    input wire logic COPY_FLAGS_I,
    input wire logic ALU_VALID_I,
    input wire fbr_alu_req_type ALU_REQ_I,
    input wire logic ALU_DONE_O,
    input wire logic SUMMARY_OVF_O,
    input wire logic OVERFLOW_O,
    input wire logic CARRY_O,
    input wire logic BR_VALID_I,
    input wire fbr_br_req_type BR_REQ_I,
    input wire logic BR_DONE_O,
    input wire fbr_br_res_type BR_RES_O,
    input wire logic [31:0] LINK_O,
    input wire logic [31:0] COUNT_O
);
    logic [31:0] a_eff;
    logic [32:0] add_sum;
    logic add_ovf;
    logic add_cry;
    logic flags_wr;
    // Whole three-term sum, never a partial one
    always_comb
    begin
        a_eff = ALU_REQ_I.invert_a ? ~ALU_REQ_I.opnd_a : ALU_REQ_I.opnd_a;
        add_sum = {1'b0, a_eff} + {1'b0, ALU_REQ_I.opnd_b} + {32'h0, (ALU_REQ_I.cin == FBR_CIN_ONE)
            || (ALU_REQ_I.cin == FBR_CIN_CARRY && CARRY_O)};
        add_ovf = (a_eff[31] == ALU_REQ_I.opnd_b[31]) && (add_sum[31] != a_eff[31]);
        add_cry = add_sum[32];
        flags_wr = CLK_EN_I && SPR_WR_I && SPR_NUM_I == `FBR_SPR_FLAGS;
    end

    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence alu_fire_s;
        ALU_VALID_I && CLK_EN_I;
    endsequence
    sequence br_fire_s;
        BR_VALID_I && CLK_EN_I;
    endsequence

    sticky_summary_a: assert property (SUMMARY_OVF_O && !flags_wr && !COPY_FLAGS_I
        |=> SUMMARY_OVF_O) else $error("summary overflow dropped");
    so_follows_ov_a: assert property (alu_fire_s ##0 (ALU_REQ_I.ovf_en &&
        ALU_REQ_I.op inside {FBR_OP_ADD, FBR_OP_MULW, FBR_OP_DIVW, FBR_OP_DIVWU})
        |=> !OVERFLOW_O || SUMMARY_OVF_O) else $error("overflow without summary");
    add_overflow_a: assert property (alu_fire_s ##0 (ALU_REQ_I.op == FBR_OP_ADD &&
        ALU_REQ_I.ovf_en) |=> ALU_DONE_O && OVERFLOW_O == $past(add_ovf))
        else $error("add overflow wrong");
    add_carry_a: assert property (alu_fire_s ##0 (ALU_REQ_I.op == FBR_OP_ADD &&
        ALU_REQ_I.carry_en) |=> CARRY_O == $past(add_cry)) else $error("add carry wrong");
    compare_keeps_a: assert property (alu_fire_s ##0 (ALU_REQ_I.op == FBR_OP_CMP &&
        !flags_wr && !COPY_FLAGS_I) |=> $stable({SUMMARY_OVF_O, OVERFLOW_O, CARRY_O}))
        else $error("compare changed flags");
    count_wrap_a: assert property (br_fire_s ##0 (!BR_REQ_I.options[2] &&
        COUNT_O == 32'h0) |=> COUNT_O == `FBR_COUNT_WRAP) else $error("count did not wrap");
    link_update_a: assert property (br_fire_s ##0 BR_REQ_I.link_en
        |=> BR_DONE_O && LINK_O == $past(BR_REQ_I.next_addr)) else $error("link not updated");
    link_target_a: assert property (br_fire_s ##0 (BR_REQ_I.tgt == FBR_TGT_LINK)
        |=> BR_RES_O.target == ($past(LINK_O) & `FBR_ADDR_MASK)) else $error("link target wrong");
    branch_always_a: assert property (br_fire_s ##0 (BR_REQ_I.options[4] &&
        BR_REQ_I.options[2]) |=> BR_RES_O.taken) else $error("always branch not taken");
    link_read_a: assert property (CLK_EN_I && SPR_RD_I && SPR_NUM_I == `FBR_SPR_LINK
        |=> SPR_RVALID_O && SPR_RDATA_O == $past(LINK_O)) else $error("link read wrong");
endmodule // fbr_core_props

// ==== testbench/fbr_issue_model.sv ====
// Decoder and execution-unit stand-in that issues ops and branches
`timescale 1ns/100ps
module fbr_issue_model
    import fbr_pkg::*;
(
    input wire logic clk_i,
    output logic alu_valid_o,
    output fbr_alu_req_type alu_req_o,
    output logic br_valid_o,
    output fbr_br_req_type br_req_o
);
    // Idle between requests
    initial
    begin
        alu_valid_o = 1'b0;
        alu_req_o = '0;
        br_valid_o = 1'b0;
        br_req_o = '0;
    end
    // One op for one cycle; inverted fields afterwards so stale data cannot pass
    task automatic issue_alu(input fbr_alu_req_type r);
        @(negedge clk_i);
        alu_valid_o = 1'b1;
        alu_req_o = r;
        @(negedge clk_i);
        alu_valid_o = 1'b0;
        alu_req_o = ~r;
    endtask
    // Options passed as given; callers keep unused bits zero except on purpose
    task automatic issue_br(input fbr_br_req_type r);
        @(negedge clk_i);
        br_valid_o = 1'b1;
        br_req_o = r;
        @(negedge clk_i);
        br_valid_o = 1'b0;
        br_req_o = ~r;
    endtask
endmodule // fbr_issue_model

// ==== testbench/fbr_core_tb.sv ====
// Self-checking bench for the flags, link and count block
`timescale 1ns/100ps
`include "fbr_regs.svh"
module fbr_core_tb
    import fbr_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0, spr_wr = 1'b0, spr_rd = 1'b0, copy = 1'b0;
    logic [9:0] spr_num = '0;
    logic [31:0] spr_wdata = '0, rdata, link, count;
    logic clk_en = 1'b1;
    logic rvalid, bad, cr_valid, alu_valid, alu_done, so, ovf, cry, br_valid, br_done;
    logic [3:0] cr_field;
    logic [6:0] bytes;
    fbr_alu_req_type alu_req;
    fbr_br_req_type br_req;
    fbr_br_res_type br_res;
    int fail_count = 0;
    int compares = 0;

    // 40 MHz core clock
    always #12.5 sys_clk = ~sys_clk;

    fbr_issue_model u_iss (.clk_i(sys_clk), .alu_valid_o(alu_valid), .alu_req_o(alu_req),
        .br_valid_o(br_valid), .br_req_o(br_req));
    fbr_core DUT (.SYS_CLK_I(sys_clk), .RST_B_I(rst_b), .CLK_EN_I(clk_en), .SPR_WR_I(spr_wr),
        .SPR_RD_I(spr_rd), .SPR_NUM_I(spr_num), .SPR_WDATA_I(spr_wdata), .SPR_RDATA_O(rdata),
        .SPR_RVALID_O(rvalid), .SPR_BAD_O(bad), .COPY_FLAGS_I(copy), .CR_FIELD_O(cr_field),
        .CR_FIELD_VALID_O(cr_valid), .ALU_VALID_I(alu_valid), .ALU_REQ_I(alu_req),
        .ALU_DONE_O(alu_done), .SUMMARY_OVF_O(so), .OVERFLOW_O(ovf), .CARRY_O(cry),
        .STRING_BYTES_O(bytes), .BR_VALID_I(br_valid), .BR_REQ_I(br_req), .BR_DONE_O(br_done),
        .BR_RES_O(br_res), .LINK_O(link), .COUNT_O(count));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic flags(input logic [2:0] e);
        check({29'h0, so, ovf, cry}, {29'h0, e});
    endtask
    // Strobe for one cycle; data inverted afterwards
    task automatic spr_write(input logic [9:0] n, input logic [31:0] d);
        @(negedge sys_clk);
        spr_wr = 1'b1;
        spr_num = n;
        spr_wdata = d;
        @(negedge sys_clk);
        spr_wr = 1'b0;
        spr_wdata = ~d;
    endtask
    task automatic spr_read(input logic [9:0] n, input logic [31:0] e, input logic is_bad);
        @(negedge sys_clk);
        spr_rd = 1'b1;
        spr_num = n;
        @(negedge sys_clk);
        spr_rd = 1'b0;
        check({30'h0, bad, rvalid}, {30'h0, is_bad, !is_bad});
        if (!is_bad)
            check(rdata, e);
    endtask
    task automatic alu(input fbr_op_type op, input logic oe, input logic ce, input logic inv,
        input fbr_cin_type ci, input logic [31:0] a, input logic [31:0] b);
        u_iss.issue_alu('{op, oe, ce, inv, ci, a, b});
        check({31'h0, alu_done}, 32'h1);
    endtask
    task automatic br(input logic [4:0] o, input logic c, input logic le, input fbr_tgt_type t,
        input logic [31:0] nx);
        u_iss.issue_br('{o, c, le, t, nx, 32'h0000_0400});
    endtask
    // Count loaded, branch issued, outcome and written-back count compared
    task automatic br_case(input logic [4:0] o, input logic c, input logic [31:0] n, input logic t);
        spr_write(`FBR_SPR_COUNT, n);
        br(o, c, 1'b0, FBR_TGT_DIRECT, 32'h0);
        check({29'h0, br_done, br_res.taken, br_res.hint}, {29'h0, 1'b1, t, o[0]});
        check(count, o[2] ? n : n - 32'h1);
    endtask
    task automatic close_out;
        if (fail_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard, well beyond the length of the sequence below
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        close_out();
    end

    // Main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_b = 1'b1;
        spr_read(`FBR_SPR_COUNT, 32'h0, 1'b0);
        spr_write(`FBR_SPR_FLAGS, 32'hffff_ffff);
        spr_read(`FBR_SPR_FLAGS, 32'he000_007f, 1'b0);
        check({25'h0, bytes}, 32'h7f);
        spr_write(`FBR_SPR_FLAGS, 32'h4000_0000);
        flags(3'b010);
        alu(FBR_OP_ADD, 1, 0, 0, FBR_CIN_ZERO, 32'h7fff_ffff, 32'h1);
        flags(3'b110);
        alu(FBR_OP_ADD, 1, 0, 0, FBR_CIN_ZERO, 32'h1, 32'h1);
        flags(3'b100);
        alu(FBR_OP_CMP, 1, 1, 0, FBR_CIN_ONE, 32'h7fff_ffff, 32'h1);
        flags(3'b100);
        @(negedge sys_clk);
        copy = 1'b1;
        @(negedge sys_clk);
        copy = 1'b0;
        check({27'h0, cr_valid, cr_field}, {27'h0, 1'b1, 4'h8});
        flags(3'b000);
        alu(FBR_OP_ADD, 0, 1, 1, FBR_CIN_ONE, 32'h1, 32'h1);
        flags(3'b001);
        alu(FBR_OP_ADD, 0, 1, 0, FBR_CIN_CARRY, 32'hffff_fffe, 32'h1);
        flags(3'b001);
        alu(FBR_OP_OTHER, 1, 1, 0, FBR_CIN_ONE, 32'hffff_ffff, 32'h1);
        flags(3'b001);
        alu(FBR_OP_SRAW, 0, 0, 0, FBR_CIN_ZERO, 32'h8000_0000, 32'h1);
        flags(3'b000);
        alu(FBR_OP_SRAW, 0, 0, 0, FBR_CIN_ZERO, 32'h8000_0001, 32'h1);
        flags(3'b001);
        alu(FBR_OP_SRAW, 0, 0, 0, FBR_CIN_ZERO, 32'h0000_0003, 32'h1);
        flags(3'b000);
        alu(FBR_OP_MULW, 1, 0, 0, FBR_CIN_ZERO, 32'h0001_0000, 32'h0001_0000);
        flags(3'b110);
        alu(FBR_OP_MULW, 1, 0, 0, FBR_CIN_ZERO, 32'h2, 32'h3);
        flags(3'b100);
        alu(FBR_OP_DIVW, 1, 0, 0, FBR_CIN_ZERO, 32'h8000_0000, 32'hffff_ffff);
        flags(3'b110);
        alu(FBR_OP_DIVWU, 1, 0, 0, FBR_CIN_ZERO, 32'h8000_0000, 32'hffff_ffff);
        flags(3'b100);
        spr_write(`FBR_SPR_FLAGS, 32'h0);
        flags(3'b000);
        spr_write(`FBR_SPR_LINK, 32'h1234_5677);
        spr_read(`FBR_SPR_LINK, 32'h1234_5677, 1'b0);
        br(5'b10100, 0, 1, FBR_TGT_LINK, 32'h0000_1000);
        check(br_res.target, 32'h1234_5674);
        check(link, 32'h0000_1000);
        br(5'b00100, 1, 1, FBR_TGT_DIRECT, 32'h0000_2220);
        check(link, 32'h0000_2220);
        // Frozen clock enable: the branch must leave link and count alone
        clk_en = 1'b0;
        br(5'b00000, 0, 1, FBR_TGT_DIRECT, 32'h0000_3330);
        clk_en = 1'b1;
        check({link[15:0], count[15:0]}, 32'h2220_0000);
        spr_write(`FBR_SPR_COUNT, 32'h0000_2003);
        br(5'b10100, 0, 0, FBR_TGT_COUNT, 32'h0);
        check(br_res.target, 32'h0000_2000);
        spr_read(`FBR_SPR_COUNT, 32'h0000_2003, 1'b0);
        br_case(5'b00000, 0, 32'h2, 1);
        br_case(5'b00000, 1, 32'h2, 0);
        br_case(5'b00010, 0, 32'h1, 1);
        br_case(5'b00010, 0, 32'h2, 0);
        br_case(5'b00001, 0, 32'h2, 1);
        br_case(5'b01000, 1, 32'h2, 1);
        br_case(5'b01010, 1, 32'h1, 1);
        br_case(5'b01010, 0, 32'h1, 0);
        br_case(5'b00100, 0, 32'h5, 1);
        br_case(5'b01100, 0, 32'h5, 0);
        br_case(5'b01111, 1, 32'h5, 1);
        br_case(5'b10000, 1, 32'h0, 1);
        br_case(5'b11010, 0, 32'h1, 1);
        br_case(5'b10100, 0, 32'h7, 1);
        spr_read(10'h003, 32'h0, 1'b1);
        close_out();
    end
endmodule // fbr_core_tb

bind fbr_core fbr_core_props u_props (.SYS_CLK_I(SYS_CLK_I), .RST_B_I(RST_B_I),
    .CLK_EN_I(CLK_EN_I), .SPR_WR_I(SPR_WR_I), .SPR_RD_I(SPR_RD_I), .SPR_NUM_I(SPR_NUM_I),
    .SPR_RDATA_O(SPR_RDATA_O), .SPR_RVALID_O(SPR_RVALID_O), .COPY_FLAGS_I(COPY_FLAGS_I),
    .ALU_VALID_I(ALU_VALID_I), .ALU_REQ_I(ALU_REQ_I), .ALU_DONE_O(ALU_DONE_O),
    .SUMMARY_OVF_O(SUMMARY_OVF_O), .OVERFLOW_O(OVERFLOW_O), .CARRY_O(CARRY_O),
    .BR_VALID_I(BR_VALID_I), .BR_REQ_I(BR_REQ_I), .BR_DONE_O(BR_DONE_O), .BR_RES_O(BR_RES_O),
    .LINK_O(LINK_O), .COUNT_O(COUNT_O));
